// *** rtl/kds_coef_ram.sv ***
`timescale 1ns/1ps
module kds_coef_ram #(
    parameter int DEPTH = 192,
    parameter int DW    = 16,
    parameter int AW    = 8
) (
    input  wire logic          clk,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [DW-1:0] wdata,
    input  wire logic [AW-1:0] raddr_a,
    output logic      [DW-1:0] rdata_a,
    input  wire logic [AW-1:0] raddr_b,
    output logic      [DW-1:0] rdata_b
);

    // Refuse a depth the address cannot reach
    if (DEPTH > (1 << AW)) begin : g_chk
        $error("kds_coef_ram: DEPTH exceeds address range");
    end

    logic [DW-1:0] mem [DEPTH];  // Coefficient storage

    // One write port, two registered read ports
    always_ff @(posedge clk) begin
        if (we && (int'(waddr) < DEPTH)) begin
            mem[waddr] <= wdata;
        end
        rdata_a <= (int'(raddr_a) < DEPTH) ? mem[raddr_a] : '0;
        rdata_b <= (int'(raddr_b) < DEPTH) ? mem[raddr_b] : '0;
    end

endmodule

// *** rtl/kds_pkg.sv ***
package kds_pkg;

    // ****************************************************************
    // Host serial framing
    // ****************************************************************
    localparam int          HDR_BITS    = 16;     // Address plus mode
    localparam logic [4:0]  COEF_LEN    = 5'h10;  // Coefficient data bits
    localparam logic [4:0]  SETUP_LEN   = 5'h18;  // Setup data bits
    localparam int          MB_READ     = 0;      // Mode bit: device sends
    localparam int          MB_TYPE     = 3;      // Mode bits 4:3: data type
    localparam int          MB_SO_ON    = 7;      // Mode bit: serial out unmuted
    localparam logic [1:0]  TYPE_SETUP  = 2'h2;   // Data type: setup word
    localparam logic [1:0]  TYPE_COEF   = 2'h1;   // Data type: coefficient memory

    // ****************************************************************
    // Setup word layout
    // ****************************************************************
    localparam logic [23:0] SETUP_RESET = 24'h000010; // Reset value
    localparam int          SB_I2S      = 11;     // Word clock framing
    localparam int          SB_WC_POL   = 10;     // Word clock polarity
    localparam int          SB_BCK_EDGE = 9;      // Bit clock edge
    localparam int          SB_SI_ORD   = 8;      // Input bit order
    localparam int          SB_SI_ALN   = 7;      // Input alignment
    localparam int          SB_SI_LEN   = 5;      // Input word length, 2 bits
    localparam int          SB_SO_ORD   = 4;      // Output bit order
    localparam int          SB_SO_ALN   = 3;      // Output alignment
    localparam int          SB_SO_LEN   = 1;      // Output word length, 2 bits
    localparam int          SB_DAC_ON   = 0;      // Converter mute release

    // ****************************************************************
    // Coefficient memory map and switch codes
    // ****************************************************************
    localparam logic [15:0] SW_DC_ON    = 16'h4000; // DC blocking enable code
    localparam logic [15:0] SW_KEY_ON   = 16'h8000; // Key / cancel enable code
    localparam logic [7:0]  SI_INPUT_LEVEL          = 8'h00;
    localparam logic [7:0]  DEEMPHASIS_SWITCH       = 8'h04;
    localparam logic [7:0]  SI_CH1_TO_LEFT_MIX      = 8'h05;
    localparam logic [7:0]  SI_CH2_TO_LEFT_MIX      = 8'h06;
    localparam logic [7:0]  ADC_CH1_TO_LEFT_MIX     = 8'h07;
    localparam logic [7:0]  ADC_CH2_TO_LEFT_MIX     = 8'h08;
    localparam logic [7:0]  SI_CH2_TO_RIGHT_MIX     = 8'h09;
    localparam logic [7:0]  SI_CH1_TO_RIGHT_MIX     = 8'h0A;
    localparam logic [7:0]  ADC_CH2_TO_RIGHT_MIX    = 8'h0B;
    localparam logic [7:0]  ADC_CH1_TO_RIGHT_MIX    = 8'h0C;
    localparam logic [7:0]  ACCOMP_DC_CUT_SWITCH    = 8'h0E;
    localparam logic [7:0]  ACCOMP_DC_CUT_FREQ      = 8'h0F;
    localparam logic [7:0]  CANCEL_PAN_CH1          = 8'h10;
    localparam logic [7:0]  CANCEL_PAN_CH2          = 8'h11;
    localparam logic [7:0]  VOICE_CANCEL_SWITCH     = 8'h18;
    localparam logic [7:0]  ACCOMP_PITCH_RATIO      = 8'h22;
    localparam logic [7:0]  ACCOMP_TRANSPOSE_SWITCH = 8'h2E;
    localparam logic [7:0]  MIC_INPUT_LEVEL         = 8'h31;
    localparam logic [7:0]  VOICE_DC_CUT_FREQ       = 8'h33;
    localparam logic [7:0]  VOICE_DC_CUT_SWITCH     = 8'h34;
    localparam logic [7:0]  VOICE_EQ_COEF_A         = 8'h35;
    localparam logic [7:0]  VOICE_EQ_COEF_B1        = 8'h36;
    localparam logic [7:0]  VOICE_EQ_COEF_B2        = 8'h37;
    localparam logic [7:0]  VOICE_EQ_GAIN           = 8'h38;
    localparam logic [7:0]  VOICE_HIGHCUT_A1        = 8'h39;
    localparam logic [7:0]  VOICE_HIGHCUT_A0        = 8'h3A;
    localparam logic [7:0]  VOICE_HIGHCUT_B         = 8'h3B;
    localparam logic [7:0]  MIC_DIRECT_MIX          = 8'h3C;
    localparam logic [7:0]  MIC_ECHO_MIX            = 8'h3D;
    localparam logic [7:0]  TRANSPOSE_OUT_LEFT_MIX  = 8'h3E;
    localparam logic [7:0]  TRANSPOSE_OUT_RIGHT_MIX = 8'h3F;
    localparam logic [7:0]  SYSTEM_VOLUME_LEFT      = 8'h40;
    localparam logic [7:0]  SYSTEM_VOLUME_RIGHT     = 8'h42;
    localparam logic [7:0]  ECHO_DELAY_LENGTH       = 8'h44;
    localparam logic [7:0]  ECHO_TAP_VOLUME         = 8'h45;
    localparam logic [7:0]  ECHO_TAP_POSITION       = 8'h47;
    localparam logic [7:0]  ECHO_INPUT_MIX          = 8'h49;
    localparam logic [7:0]  ECHO_FEEDBACK_MIX       = 8'h4A;
    localparam logic [7:0]  ECHO_HIGHCUT_A1         = 8'h4B;
    localparam logic [7:0]  ECHO_HIGHCUT_A0         = 8'h4C;
    localparam logic [7:0]  ECHO_HIGHCUT_B          = 8'h4D;
    localparam logic [7:0]  VOICE_PITCH_RATIO       = 8'h53;
    localparam logic [7:0]  MIC_INPUT_MIX           = 8'h5A;
    localparam logic [7:0]  VOICE_PITCH_OUT_MIX     = 8'h5B;

    // Transfer phases of the host port
    typedef enum logic [2:0] {
        PH_HDR, PH_WDATA, PH_WSLOT, PH_RSLOT, PH_RFETCH, PH_RDATA
    } kds_phase_t;

endpackage

// *** rtl/kds_setup_coef.sv ***
// Overview of operation
// R1 - Host keeps setup bits 23:12 zero; reset clears
// R2 - Setup bit 11 picks normal or I2S framing
// R3 - Setup bit 10 sets word clock polarity
// R4 - Setup bit 9 picks aligned bit clock edge
// R5 - Setup bit 8 input order; LSB implies rear
// R6 - Setup bit 7 picks input front/rear truncation
// R7 - Setup bits 6:5 set input word length
// R8 - Setup bit 4 output order; reset LSB first
// R9 - Setup bit 3 picks output truncation
// R10 - Setup bits 2:1 set output word length
// R11 - Setup bit 0 releases converter mute
// R12 - Host loads fixed constants at initialisation
// R13 - Unlisted coefficient words affect nothing
// R14 - DC blocking on at 4000H, off at 0000H
// R15 - Centre cancel: switch 8000H, pans 7000H
// R16 - Cancel off: switch and pans 0000H
// R17 - Pan one drives channel 1, two channel 2
// R18 - Pitch ratio is bits 15:2 two's complement
// R19 - Pitch ratio low two bits ignored
// R20 - Pitch ratio is two to cents/1200 minus one
// R21 - Pitch rewrites cause no audible artefacts
// R22 - Host keeps pitch within one octave
// R23 - Key off: clear pitch, then switches
// R24 - Key control on at 8000H, through at 0000H
// R25 - 192 words of 16 bits; setup one word
// R26 - All host fields shift LSB first
// R27 - Host writes apply only at update slot
`timescale 1ns/1ps
module kds_setup_coef #(
    parameter int DEPTH = 192,
    parameter int AW    = 8
) (
    input  wire logic        mclk,
    input  wire logic        arst_n,
    input  wire logic        sck,
    input  wire logic        rvdt,
    input  wire logic        xlat,
    input  wire logic        word_clock,
    output logic             ready,
    output logic             trdt_o,
    output logic             trdt_oe,
    output logic             so_unmute,
    output logic             i2s_framing,
    output logic             word_clock_left_low,
    output logic             bit_clock_rising,
    output logic             si_lsb_first,
    output logic             si_rear_trunc,
    output logic [1:0]       si_word_len,
    output logic             so_lsb_first,
    output logic             so_rear_trunc,
    output logic [1:0]       so_word_len,
    output logic             dac_unmute,
    output logic             accomp_dc_cut_en,
    output logic             voice_dc_cut_en,
    output logic             voice_cancel_en,
    output logic [15:0]      cancel_pan_ch1,
    output logic [15:0]      cancel_pan_ch2,
    output logic             accomp_transpose_en,
    output logic [13:0]      accomp_pitch_ratio,
    output logic [13:0]      voice_pitch_ratio,
    input  wire logic [AW-1:0] proc_addr,
    output logic      [15:0] proc_data
);
    import kds_pkg::*;

    // Refuse a depth the address cannot reach
    if (DEPTH > (1 << AW) || AW < 8) begin : g_chk
        $error("kds_setup_coef: bad DEPTH or AW");
    end

    // ****************************************************************
    // Link side: shift register on the host shift clock
    // ****************************************************************
    typedef struct packed {
        logic [23:0] sh;          // Last 24 bits, newest at the top
    } kds_link_t;

    kds_link_t lq;                // Link state
    kds_link_t ld;                // Link next state

    // Each shift clock rise moves one bit in, oldest bit lands lowest
    always_comb begin
        ld    = lq;
        ld.sh = {rvdt, lq.sh[23:1]};  // see R26
    end

    // Link register, cleared by system reset
    always_ff @(posedge sck or negedge arst_n) begin
        if (!arst_n) begin
            lq <= '0;
        end else begin
            lq <= ld;
        end
    end

    // ****************************************************************
    // Core side state
    // ****************************************************************
    typedef struct packed {
        kds_phase_t  phase;       // Transfer phase
        logic [2:0]  sck_s;       // Shift clock synchroniser and delay
        logic [2:0]  xlat_s;      // Latch synchroniser and delay
        logic [2:0]  wclk_s;      // Word clock synchroniser and delay
        logic [15:0] hdr;         // Captured address and mode
        logic [4:0]  cnt;         // Data bit counter
        logic [23:0] wdata;       // Captured write data
        logic [23:0] rsr;         // Read data shifter
        logic        trdt;        // Serial read bit
        logic        oe;          // Read pin drive
        logic        so_on;       // Serial output unmute
        logic [23:0] setup;       // Setup word
        logic        acc_dc;      // Accompaniment DC blocking
        logic        voc_dc;      // Voice DC blocking
        logic        vc;          // Voice cancel
        logic        ks;          // Accompaniment key control
        logic [15:0] pan1;        // Cancel pan, channel 1
        logic [15:0] pan2;        // Cancel pan, channel 2
        logic [13:0] acc_pitch;   // Accompaniment pitch ratio
        logic [13:0] voc_pitch;   // Voice pitch ratio
    } kds_ctl_t;

    kds_ctl_t q;                  // Current state
    kds_ctl_t d;                  // Next state

    logic        sck_rise;        // Synchronised shift clock rise
    logic        sck_fall;        // Synchronised shift clock fall
    logic        xlat_rise;       // Synchronised latch rise
    logic        slot;            // Once-per-sample update slot
    logic [7:0]  addr;            // Header address
    logic        is_setup;        // Header selects the setup word
    logic        in_range;        // Address inside the memory
    logic [4:0]  len;             // Data length of this transfer
    logic        wr_coef;         // Coefficient write this cycle
    logic        wr_setup;        // Setup write this cycle
    logic [15:0] ram_rd;          // Host read data from memory

    // Edge detectors look only at the second and third stages
    assign sck_rise  = q.sck_s[1] & ~q.sck_s[2];
    assign sck_fall  = ~q.sck_s[1] & q.sck_s[2];
    assign xlat_rise = q.xlat_s[1] & ~q.xlat_s[2];
    assign slot      = q.wclk_s[1] & ~q.wclk_s[2];

    // Header decode
    assign addr      = q.hdr[7:0];  // see R26
    assign is_setup  = (q.hdr[8+MB_TYPE+:2] == TYPE_SETUP);
    assign in_range  = (int'(addr) < DEPTH);  // see R25
    assign len       = is_setup ? SETUP_LEN : COEF_LEN;

    // Writes land only in the update slot
    assign wr_setup  = (q.phase == PH_WSLOT) && slot && is_setup;  // see R27
    assign wr_coef   = (q.phase == PH_WSLOT) && slot && !is_setup && in_range;  // see R27

    // ****************************************************************
    // Coefficient memory
    // ****************************************************************
    kds_coef_ram #(
        .DEPTH (DEPTH),
        .DW    (16),
        .AW    (AW)
    ) u_ram (
        .clk     (mclk),
        .we      (wr_coef),
        .waddr   (AW'(addr)),
        .wdata   (q.wdata[15:0]),
        .raddr_a (AW'(addr)),
        .rdata_a (ram_rd),
        .raddr_b (proc_addr),
        .rdata_b (proc_data)
    );

    // ****************************************************************
    // Transfer sequencer and configuration update
    // ****************************************************************
    always_comb begin
        d        = q;
        // Two flip-flops before any logic reads a pin
        d.sck_s  = {q.sck_s[1:0], sck};
        d.xlat_s = {q.xlat_s[1:0], xlat};
        d.wclk_s = {q.wclk_s[1:0], word_clock};

        unique case (q.phase)
            // Header phase: the link shifter holds address and mode
            PH_HDR: begin
                if (xlat_rise) begin
                    // Header bits are stable: no shift edge until data
                    d.hdr   = lq.sh[23:8];  // see R26
                    d.so_on = lq.sh[16+MB_SO_ON];
                    d.cnt   = '0;
                    if (lq.sh[16+MB_TYPE+:2] == TYPE_SETUP ||
                        lq.sh[16+MB_TYPE+:2] == TYPE_COEF) begin
                        if (lq.sh[16+MB_READ]) begin
                            d.phase = PH_RSLOT;
                            d.oe    = 1'b1;
                        end else begin
                            d.phase = PH_WDATA;
                        end
                    end
                end
            end
            // Count write data bits until the word is complete
            PH_WDATA: begin
                if (sck_rise) begin
                    d.cnt = q.cnt + 5'h01;
                    if (q.cnt == len - 5'h01) begin
                        // Short words sit in the top of the shifter
                        d.wdata = is_setup ? lq.sh : {8'h00, lq.sh[23:8]};
                        d.phase = PH_WSLOT;
                    end
                end
            end
            // Wait for the update slot, then commit
            PH_WSLOT: begin
                if (slot) begin
                    d.phase = PH_HDR;
                end
            end
            // Read waits for the slot too, so it sees a settled word
            PH_RSLOT: begin
                if (slot) begin
                    d.phase = PH_RFETCH;  // see R27
                end
            end
            // Memory read data is registered, load the shifter
            PH_RFETCH: begin
                d.rsr   = is_setup ? q.setup
                                   : {8'h00, (in_range ? ram_rd : 16'h0000)};
                d.cnt   = '0;
                d.phase = PH_RDATA;
            end
            // Present one bit per falling edge, count rising edges
            PH_RDATA: begin
                if (sck_fall) begin
                    d.trdt = q.rsr[0];  // see R26
                    d.rsr  = {1'b0, q.rsr[23:1]};
                end
                if (sck_rise) begin
                    d.cnt = q.cnt + 5'h01;
                    if (q.cnt == len - 5'h01) begin
                        d.phase = PH_HDR;
                        d.oe    = 1'b0;
                    end
                end
            end
            default: begin
                d.phase = PH_HDR;
            end
        endcase

        // Setup word takes the whole data section
        if (wr_setup) begin
            d.setup = q.wdata;  // see R27
        end

        // Decoded copies of the words the processing reads live
        if (wr_coef) begin
            unique case (addr)
                ACCOMP_DC_CUT_SWITCH:    d.acc_dc = (q.wdata[15:0] == SW_DC_ON);   // see R14
                VOICE_DC_CUT_SWITCH:     d.voc_dc = (q.wdata[15:0] == SW_DC_ON);   // see R14
                VOICE_CANCEL_SWITCH:     d.vc     = (q.wdata[15:0] == SW_KEY_ON);
                ACCOMP_TRANSPOSE_SWITCH: d.ks     = (q.wdata[15:0] == SW_KEY_ON);  // see R24
                CANCEL_PAN_CH1:          d.pan1   = q.wdata[15:0];  // see R17
                CANCEL_PAN_CH2:          d.pan2   = q.wdata[15:0];  // see R17
                ACCOMP_PITCH_RATIO: begin
                    // Only at the slot, so the shifter never sees a glitch
                    d.acc_pitch = q.wdata[15:2];  // see R18 see R19 see R20 see R21
                end
                VOICE_PITCH_RATIO: begin
                    d.voc_pitch = q.wdata[15:2];  // see R18 see R19 see R21
                end
                default: begin
                    // Other words only reach the memory, read by the processing and host ports, see R13
                end
            endcase
        end
    end

    // Core register, set by system reset: setup to SETUP_RESET, sck_s all high, the rest cleared
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            q       <= '0;
            q.phase <= PH_HDR;
            q.sck_s <= 3'h7;  // Shift clock idles high: no false rise
            q.setup <= SETUP_RESET;  // see R1 see R8 see R11
        end else begin
            q <= d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign ready               = (q.phase == PH_HDR) || (q.phase == PH_WDATA) ||
                                 (q.phase == PH_RDATA);
    assign trdt_o              = q.trdt;
    assign trdt_oe             = q.oe;
    assign so_unmute           = q.so_on;
    assign i2s_framing         = q.setup[SB_I2S];  // see R2
    assign word_clock_left_low = q.setup[SB_WC_POL];  // see R3
    assign bit_clock_rising    = q.setup[SB_BCK_EDGE];  // see R4
    assign si_lsb_first        = q.setup[SB_SI_ORD];  // see R5
    assign si_rear_trunc       = q.setup[SB_SI_ALN] | q.setup[SB_SI_ORD];  // see R5 see R6
    assign si_word_len         = q.setup[SB_SI_LEN+:2];  // see R7
    assign so_lsb_first        = q.setup[SB_SO_ORD];  // see R8
    assign so_rear_trunc       = q.setup[SB_SO_ALN];  // see R9
    assign so_word_len         = q.setup[SB_SO_LEN+:2];  // see R10
    assign dac_unmute          = q.setup[SB_DAC_ON];  // see R11
    assign accomp_dc_cut_en    = q.acc_dc;
    assign voice_dc_cut_en     = q.voc_dc;
    assign voice_cancel_en     = q.vc;
    assign cancel_pan_ch1      = q.pan1;
    assign cancel_pan_ch2      = q.pan2;
    assign accomp_transpose_en = q.ks;
    assign accomp_pitch_ratio  = q.acc_pitch;
    assign voice_pitch_ratio   = q.voc_pitch;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    // Setup changes only in the cycle after an update slot
    setup_slot_a: assert property ( // see R27
        $changed(q.setup) |-> $past(slot) && $past(q.phase == PH_WSLOT))
        else $error("setup word changed outside the update slot");

    // A completed setup write lands at the next slot
    setup_write_a: assert property ( // see R27
        wr_setup |=> (q.setup == $past(q.wdata)) && (q.phase == PH_HDR))
        else $error("setup write not applied");

    // Rear alignment follows LSB-first input
    si_rear_a: assert property ( // see R5
        si_lsb_first |-> si_rear_trunc)
        else $error("LSB-first input without rear alignment");

    // DC blocking switch word decodes exactly
    dc_switch_a: assert property ( // see R14
        wr_coef && addr == ACCOMP_DC_CUT_SWITCH
        |=> accomp_dc_cut_en == ($past(q.wdata[15:0]) == SW_DC_ON))
        else $error("accompaniment DC blocking decode wrong");

    // Key control switch decodes exactly
    key_switch_a: assert property ( // see R24
        wr_coef && addr == ACCOMP_TRANSPOSE_SWITCH
        |=> accomp_transpose_en == ($past(q.wdata[15:0]) == SW_KEY_ON))
        else $error("key control switch decode wrong");

    // Pitch ratio drops the two low bits
    pitch_bits_a: assert property ( // see R19
        wr_coef && addr == VOICE_PITCH_RATIO
        |=> voice_pitch_ratio == $past(q.wdata[15:2]))
        else $error("voice pitch ratio field wrong");

    // Pitch ratio is stable between slots
    pitch_hold_a: assert property ( // see R21
        !slot |=> $stable(accomp_pitch_ratio) && $stable(voice_pitch_ratio))
        else $error("pitch ratio changed between slots");

    // Channel 2 pan word lands on channel 2, channel 1 holds
    pan_channel_a: assert property ( // see R17
        wr_coef && addr == CANCEL_PAN_CH2
        |=> cancel_pan_ch2 == $past(q.wdata[15:0]) && $stable(cancel_pan_ch1))
        else $error("pan weight landed on wrong channel");

    // Ready stays low and the read pin drives while a read waits for its slot
    ready_wait_a: assert property ( // see R27
        q.phase == PH_RSLOT && !slot |=> !ready [*1] ##0 q.oe)
        else $error("ready high or read pin idle while waiting");

endmodule

// *** sim/karaoke_dsp_setup_and_coefficients_test.sv ***
`timescale 1ns/1ps
module karaoke_dsp_setup_and_coefficients_test;
    import kds_pkg::*;
    logic        mclk, arst_n, sck, rvdt, xlat, word_clock, ready, trdt_o, trdt_oe;
    logic        so_unmute, i2s_framing, word_clock_left_low, bit_clock_rising, si_lsb_first;
    logic        si_rear_trunc, so_lsb_first, so_rear_trunc, dac_unmute, accomp_dc_cut_en;
    logic        voice_dc_cut_en, voice_cancel_en, accomp_transpose_en;
    logic [1:0]  si_word_len, so_word_len;
    logic [13:0] accomp_pitch_ratio, voice_pitch_ratio;
    logic [15:0] cancel_pan_ch1, cancel_pan_ch2, proc_data, mem [int];
    logic [7:0]  proc_addr, ad [8] = '{8'h0E, 8'h34, 8'h18, 8'h2E, 8'h10, 8'h11, 8'h22, 8'h53};
    logic [15:0] cv [4] = '{16'h4000, 16'h8000, 16'h7000, 16'h0000};
    logic [7:0]  ko [4] = '{8'h22, 8'h53, 8'h2E, 8'h5B};
    logic [31:0] lfsr = 32'h561F;
    logic [23:0] q, su;
    int          n_errors = 0, checked = 0, cyc = 0;
    kds_setup_coef DUT (.*);
    kds_host host (.*);
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // Word clock slots and hang limit
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        word_clock <= cyc[5];
        if (cyc == 80000) begin
            n_errors++;
            summarize();
        end
    end
    function automatic logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Setup outputs, bit 11 down to bit 0
    function automatic logic [11:0] sg();
        return {i2s_framing, word_clock_left_low, bit_clock_rising, si_lsb_first,
                si_rear_trunc, si_word_len, so_lsb_first, so_rear_trunc, so_word_len, dac_unmute};
    endfunction
    // Decoded words expected from the model memory
    function automatic logic [63:0] dec();
        return {mem[8'h0E] === SW_DC_ON, mem[8'h34] === SW_DC_ON, mem[8'h18] === SW_KEY_ON,
                mem[8'h2E] === SW_KEY_ON, mem[8'h10], mem[8'h11], mem[8'h22][15:2],
                mem[8'h53][15:2]};
    endfunction
    // Decoded outputs as the design shows them
    function automatic logic [63:0] dg();
        return {accomp_dc_cut_en, voice_dc_cut_en, voice_cancel_en, accomp_transpose_en,
                cancel_pan_ch1, cancel_pan_ch2, accomp_pitch_ratio, voice_pitch_ratio};
    endfunction
    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %0t got %h want %h", $time, g, e);
        end
    endtask
    // Write a word, then read it back
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        host.xfer({8'h08, a}, {8'h00, d}, 16, q);
        if (a < 8'hC0) mem[a] = d;
        host.xfer({8'h09, a}, 24'h0, 16, q);
        chk(q[15:0], (a < 8'hC0) ? mem[a] : 16'h0);
    endtask
    task automatic summarize();
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        arst_n = 1'b0;
        proc_addr = 8'h00;
        repeat (5) @(posedge mclk);
        #1 chk({ready, trdt_oe, so_unmute, sg()}, {3'b100, 12'h010});
        arst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        foreach (ad[i]) wr(ad[i], 16'h0000);
        for (int k = 0; k < 24; k++) begin
            lfsr = nx(lfsr);
            wr(ad[k % 8], (k < 16) ? cv[(k / 8 + k / 2) % 4]
                                   : {{3{lfsr[15]}}, lfsr[12:0]});
            chk(dg(), dec());
        end
        wr(8'hBF, 16'hA5C3);
        wr(8'hC0, 16'h1234);
        chk(dg(), dec());
        wr(8'h01, 16'h68A9);
        wr(8'h22, 16'h4000);
        wr(8'h53, 16'hE000);
        chk({accomp_pitch_ratio, voice_pitch_ratio}, {14'h1000, 14'h3800});
        foreach (ko[i]) wr(ko[i], 16'h0000);
        chk(dg(), dec());
        for (int k = 0; k < 8; k++) begin
            lfsr = nx(lfsr);
            su = {12'h000, lfsr[11:0]};
            host.xfer({lfsr[31], 7'h10, lfsr[23:16]}, su, 24, q);
            chk({so_unmute, sg()}, {lfsr[31], su[11:8], su[8] | su[7], su[6:0]});
            host.xfer({8'h11, 8'h00}, 24'h0, 24, q);
            chk(q, su);
        end
        foreach (ad[i]) begin
            @(posedge mclk) proc_addr <= ad[i];
            @(posedge mclk);
            #1 chk(proc_data, mem[ad[i]]);
        end
        summarize();
    end
endmodule

// *** sim/kds_host.sv ***
`timescale 1ns/1ps
// Host end of the control link; sck stands high between frames
module kds_host (
    output logic sck,
    output logic rvdt,
    output logic xlat,
    input  wire logic ready,
    input  wire logic trdt_o
);
    initial {sck, rvdt, xlat} = 3'b100;
    // One bit: fall and present, sample at rise
    task automatic bx(input logic b, output logic r);
        sck = 1'b0;
        rvdt = b;
        #45 sck = 1'b1;
        r = trdt_o;
        #45;
    endtask
    // Header, latch, wait for ready (the slot on reads only), data, wait again
    task automatic xfer(input logic [15:0] h, input logic [23:0] d, input int n,
                        output logic [23:0] q);
        q = '0;
        xlat = 1'b0;
        for (int i = 0; i < 16; i++) bx(h[i], q[0]);
        #20 xlat = 1'b1;
        #50 wait (ready === 1'b1);
        for (int i = 0; i < n; i++) bx(d[i], q[i]);
        wait (ready === 1'b1);
        #1; // Let the committed outputs settle past the commit edge
        rvdt = ~rvdt; // Released line shows the inverse
    endtask
endmodule
